/* hdl/pef_defines.vh */
/*
 * Constants for the peripheral event flag block: register byte
 * offsets, flag bit positions, reset values and capture/compare
 * mode codes.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef PEF_DEFINES_VH
`define PEF_DEFINES_VH

// ****************************************************************
// Register byte offsets on the APB
// ****************************************************************
`define PEF_OFS_FLAGS 8'h00
`define PEF_OFS_MASK 8'h04
`define PEF_OFS_SET 8'h08
`define PEF_OFS_MODE 8'h0C
`define PEF_OFS_STATUS 8'h10
`define PEF_OFS_OVERRUN 8'h14

// ****************************************************************
// Flag bit positions
// ****************************************************************
`define PEF_BIT_NV_WRITE_DONE 7
`define PEF_BIT_CONVERTER_DONE 6
`define PEF_BIT_CAPCOMP_EVENT 5
`define PEF_BIT_CMP_B_CHANGE 4
`define PEF_BIT_CMP_A_CHANGE 3
`define PEF_BIT_CLOCK_FAIL 2
`define PEF_BIT_TIMER_B_MATCH 1
`define PEF_BIT_TIMER_A_OVERFLOW 0

// ****************************************************************
// Reset values
// ****************************************************************
`define PEF_RST_FLAGS 8'h00
`define PEF_RST_MASK 8'h00
`define PEF_RST_MODE 2'h0

// ****************************************************************
// Capture/compare unit modes
// ****************************************************************
`define PEF_MODE_OFF 2'h0
`define PEF_MODE_CAPTURE 2'h1
`define PEF_MODE_COMPARE 2'h2
`define PEF_MODE_PWM 2'h3

`endif

/* hdl/pef_top.v */
/*
 * Peripheral event flag register with interrupt mask, reached
 * over an APB slave port.
 * An overrun register records events that hit a set flag.
 * Assumes event inputs are synchronous to clock; pulse inputs are
 * high for one cycle per event, levels are held by the source.
 */
// Summary of operation
// R1: Write completion sets top flag, sticky
// R2: Conversion complete sets converter done flag
// R3: Capture mode: capture sets capture/compare flag
// R4: Compare mode: match sets flag; PWM unused
// R5: Comparator B output change sets flag
// R6: Comparator A output change sets flag
// R7: Switch to internal oscillator sets fail flag
// R8: Timer B period match sets flag
// R9: Timer A overflow sets lowest flag
// R10: Flags set regardless of any enable bits
// R11: Software clears stale flags before enabling
// R12: Flags read/write, reset zero, set wins
`timescale 1ns/1ns
`include "pef_defines.vh"

module pef_top
#(
    parameter ADDR_W = 8,
    parameter FLAG_W = 8
)
(
    clock,
    rst,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    pstrb,
    prdata,
    pready,
    pslverr,
    nv_write_done,
    converter_done,
    capture_event,
    compare_match,
    cmp_b_out,
    cmp_a_out,
    on_internal_oscillator,
    timer_b_match,
    timer_a_overflow,
    irq
);

input wire clock;
input wire rst;
input wire psel;
input wire penable;
input wire pwrite;
input wire [ADDR_W-1:0] paddr;
input wire [31:0] pwdata;
input wire [3:0] pstrb;
output reg [31:0] prdata;
output reg pready;
output reg pslverr;
input wire nv_write_done;
input wire converter_done;
input wire capture_event;
input wire compare_match;
input wire cmp_b_out;
input wire cmp_a_out;
input wire on_internal_oscillator;
input wire timer_b_match;
input wire timer_a_overflow;
output reg irq;

// ****************************************************************
// State
// ****************************************************************
reg [FLAG_W-1:0] flags_reg;
reg [FLAG_W-1:0] flags_next;
reg [FLAG_W-1:0] mask_reg;
reg [FLAG_W-1:0] mask_next;
reg [FLAG_W-1:0] overrun_reg;
reg [FLAG_W-1:0] overrun_next;
reg [1:0] mode_reg;
reg [1:0] mode_next;
reg primed_reg;
reg cmp_b_prev_reg;
reg cmp_a_prev_reg;
reg osc_prev_reg;
reg [FLAG_W-1:0] event_vec;
reg [FLAG_W-1:0] clear_vec;
reg [FLAG_W-1:0] ovr_clear_vec;
reg [FLAG_W-1:0] set_vec;
reg [31:0] rdata_next;
reg addr_ok;
reg irq_next;
wire setup;
wire wr_fire;
wire lane0;
wire rd_take;
wire wr_take;
wire wr_flags;
wire wr_set;
wire wr_mask;
wire wr_mode;
wire wr_ovr;
wire cmp_b_toggle;
wire cmp_a_toggle;
wire osc_switch;

// ****************************************************************
// APB decode
// ****************************************************************
assign setup = psel & ~penable;
assign wr_fire = psel & penable & pwrite & pready & ~pslverr;
assign lane0 = pstrb[0];
// Read data is launched at setup so it stands in the access cycle
assign rd_take = setup & ~pwrite & addr_ok;

// Writes with the low byte lane off change nothing
assign wr_take = wr_fire & lane0;
assign wr_flags = wr_take & (paddr == `PEF_OFS_FLAGS);
assign wr_set = wr_take & (paddr == `PEF_OFS_SET);
assign wr_mask = wr_take & (paddr == `PEF_OFS_MASK);
assign wr_mode = wr_take & (paddr == `PEF_OFS_MODE);
assign wr_ovr = wr_take & (paddr == `PEF_OFS_OVERRUN);

always @*
begin
    case (paddr)
        `PEF_OFS_FLAGS,
        `PEF_OFS_MASK,
        `PEF_OFS_SET,
        `PEF_OFS_MODE,
        `PEF_OFS_STATUS,
        `PEF_OFS_OVERRUN:
            addr_ok = 1'b1;
        default:
            addr_ok = 1'b0;
    endcase
end

always @*
begin
    rdata_next = 32'h0000_0000;
    case (paddr)
        `PEF_OFS_FLAGS:
            rdata_next[FLAG_W-1:0] = flags_reg;
        `PEF_OFS_MASK:
            rdata_next[FLAG_W-1:0] = mask_reg;
        `PEF_OFS_MODE:
            rdata_next[1:0] = mode_reg;
        `PEF_OFS_STATUS:
        begin
            // Pending unmasked flags, then registered peripheral levels
            rdata_next[FLAG_W-1:0] = flags_reg & mask_reg;
            rdata_next[8] = cmp_a_prev_reg;
            rdata_next[9] = cmp_b_prev_reg;
            rdata_next[10] = osc_prev_reg;
        end
        `PEF_OFS_OVERRUN:
            rdata_next[FLAG_W-1:0] = overrun_reg;
        default:
            rdata_next = 32'h0000_0000;
    endcase
end

// ****************************************************************
// Bus answer: one wait-free access phase
// ****************************************************************
always @(posedge clock)
begin
    if (rst)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
    end
    else
    begin
        pready <= setup;
        pslverr <= setup & ~addr_ok;
        if (rd_take)
        begin
            prdata <= rdata_next;
        end
        else
        begin
            prdata <= 32'h0000_0000;
        end
    end
end

// ****************************************************************
// Event detection
// ****************************************************************
always @(posedge clock)
begin
    if (rst)
    begin
        primed_reg <= 1'b0;
        cmp_b_prev_reg <= 1'b0;
        cmp_a_prev_reg <= 1'b0;
        osc_prev_reg <= 1'b0;
    end
    else
    begin
        // Levels are first sampled after reset without flagging
        primed_reg <= 1'b1;
        cmp_b_prev_reg <= cmp_b_out;
        cmp_a_prev_reg <= cmp_a_out;
        osc_prev_reg <= on_internal_oscillator;
    end
end

// ****************************************************************
// Level change detection
// ****************************************************************
// No level change is flagged until the previous levels hold real samples
assign cmp_b_toggle = primed_reg & (cmp_b_out ^ cmp_b_prev_reg);
assign cmp_a_toggle = primed_reg & (cmp_a_out ^ cmp_a_prev_reg);
assign osc_switch = primed_reg & on_internal_oscillator & ~osc_prev_reg;

always @*
begin
    event_vec = {FLAG_W{1'b0}};
    event_vec[`PEF_BIT_NV_WRITE_DONE] = nv_write_done; // see R1
    event_vec[`PEF_BIT_CONVERTER_DONE] = converter_done; // see R2
    case (mode_reg)
        `PEF_MODE_CAPTURE:
            event_vec[`PEF_BIT_CAPCOMP_EVENT] = capture_event; // see R3
        `PEF_MODE_COMPARE:
            event_vec[`PEF_BIT_CAPCOMP_EVENT] = compare_match; // see R4
        default:
            event_vec[`PEF_BIT_CAPCOMP_EVENT] = 1'b0; // see R4
    endcase
    event_vec[`PEF_BIT_CMP_B_CHANGE] = cmp_b_toggle; // see R5
    event_vec[`PEF_BIT_CMP_A_CHANGE] = cmp_a_toggle; // see R6
    event_vec[`PEF_BIT_CLOCK_FAIL] = osc_switch; // see R7
    event_vec[`PEF_BIT_TIMER_B_MATCH] = timer_b_match; // see R8
    event_vec[`PEF_BIT_TIMER_A_OVERFLOW] = timer_a_overflow; // see R9
end

// ****************************************************************
// Software write strobes
// ****************************************************************
always @*
begin
    clear_vec = {FLAG_W{1'b0}};
    ovr_clear_vec = {FLAG_W{1'b0}};
    set_vec = {FLAG_W{1'b0}};
    mask_next = mask_reg;
    mode_next = mode_reg;
    if (wr_flags)
    begin
        clear_vec = pwdata[FLAG_W-1:0]; // see R12
    end
    if (wr_set)
    begin
        set_vec = pwdata[FLAG_W-1:0]; // see R12
    end
    if (wr_mask)
    begin
        mask_next = pwdata[FLAG_W-1:0];
    end
    if (wr_mode)
    begin
        mode_next = pwdata[1:0];
    end
    if (wr_ovr)
    begin
        ovr_clear_vec = pwdata[FLAG_W-1:0];
    end
end

// ****************************************************************
// Sticky flags, one per bit
// ****************************************************************
genvar i;
generate
    for (i = 0; i < FLAG_W; i = i + 1)
    begin : g_flag
        always @*
        begin
            // Event or software set wins over a same-cycle clear
            flags_next[i] = event_vec[i] | set_vec[i] |
                (flags_reg[i] & ~clear_vec[i]); // see R10, R12
            // Event landing on an already set flag is recorded
            overrun_next[i] = (event_vec[i] & flags_reg[i]) |
                (overrun_reg[i] & ~ovr_clear_vec[i]);
        end
    end
endgenerate

always @(posedge clock)
begin
    if (rst)
    begin
        flags_reg <= `PEF_RST_FLAGS; // see R12
        overrun_reg <= `PEF_RST_FLAGS;
    end
    else
    begin
        flags_reg <= flags_next;
        overrun_reg <= overrun_next;
    end
end

// ****************************************************************
// Control registers
// ****************************************************************
always @(posedge clock)
begin
    if (rst)
    begin
        mask_reg <= `PEF_RST_MASK;
        mode_reg <= `PEF_RST_MODE;
    end
    else
    begin
        mask_reg <= mask_next;
        mode_reg <= mode_next;
    end
end

// ****************************************************************
// Interrupt output
// ****************************************************************
always @*
begin
    // Level interrupt tracks the state the flops are taking
    irq_next = |(flags_next & mask_next);
end

always @(posedge clock)
begin
    if (rst)
    begin
        irq <= 1'b0;
    end
    else
    begin
        irq <= irq_next;
    end
end

endmodule

/* tb/pef_properties.sv */
/* Port checker for pef_top.
   Assumes a bind to pef_top and a one-clock, zero-wait APB. */
`timescale 1ns/1ns
module pef_properties
#(
    parameter ADDR_W = 8
)
(
    input wire clock,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire irq
);
// ********************
// Bus phases
// ********************
wire mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h14);
sequence s_setup;
    psel && !penable;
endsequence
sequence s_wr_access;
    psel && penable && pwrite;
endsequence
default clocking cb_main @(posedge clock);
endclocking
default disable iff (rst);
a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
a_err_in_access: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
a_data_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero while idle");
a_unmapped_err: assert property ((s_setup and !mapped) |=>
    pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
a_mapped_ok: assert property ((s_setup and mapped) |=> !pslverr)
    else $error("mapped access refused");
a_write_answered: assert property (s_setup ##1 s_wr_access |-> pready)
    else $error("write access not answered");
a_upper_zero: assert property (pready |-> prdata[31:11] == 21'h0)
    else $error("unused read bits set");
a_irq_sticky: assert property (irq && !(psel && penable && pwrite) |=> irq)
    else $error("irq dropped without a write");
a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !irq && !pready && !pslverr)
    else $error("outputs active after reset");
endmodule

bind pef_top pef_properties #(.ADDR_W(ADDR_W)) i_props (.clock(clock),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq));

/* tb/test_peripheral_event_flag_register.sv */
/* Self-checking bench for pef_top.
   Assumes the bound port checker and zero-wait APB answers. */
`timescale 1ns/1ns
module test_peripheral_event_flag_register;
logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
logic pwrite = 1'b0, cm = 1'b0, ca = 1'b0, cb = 1'b0, osc = 1'b0, err;
logic [7:0] paddr = 8'h00, ev = 8'h00, f = 8'h00, m = 8'h00;
logic [31:0] pwdata = 32'h0, rd, r;
logic [3:0] pstrb = 4'hf;
logic [1:0] md = 2'h0;
wire [31:0] prdata;
wire pready, pslverr, irq;
int fails = 0, check_count = 0, cyc = 0, i;
pef_top i_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nv_write_done(ev[7]), .converter_done(ev[6]), .capture_event(ev[5]),
    .compare_match(cm), .cmp_b_out(cb), .cmp_a_out(ca),
    .on_internal_oscillator(osc), .timer_b_match(ev[1]),
    .timer_a_overflow(ev[0]), .irq(irq));
always #25 clock = ~clock;
// ********************
// Tasks
// ********************
function logic [7:0] want(input logic [7:0] e, input logic c);
    want = e & (osc ? 8'hdb : 8'hdf);
    want[5] = (md == 2'h1 && e[5]) || (md == 2'h2 && c);
endfunction
task close_out;
    if (fails == 0 && check_count > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask
task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
        fails++;
        $display("BAD %0t got %h exp %h", $time, got, exp);
    end
endtask
task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
endtask
task rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, 4'hf);
    chk(rd, x);
endtask
task pulse(input logic [7:0] e, input logic c);
    f = f | want(e, c);
    @(posedge clock);
    ev <= e;
    cm <= c;
    ca <= ca ^ e[3];
    cb <= cb ^ e[4];
    osc <= osc ^ e[2];
    @(posedge clock);
    ev <= 8'h00;
    cm <= 1'b0;
endtask
// ********************
// Sequence
// ********************
always @(posedge clock)
begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
        fails++;
        close_out;
    end
end
initial
begin
    void'($urandom(32'hed02d88e));
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    rdc(8'h00, 32'h0);
    rdc(8'h0c, 32'h0);
    for (i = 0; i < 4; i++)
    begin
        md = i[1:0];
        wr(8'h0c, {30'h0, md});
        pulse(8'h20, 1'b0);
        pulse(8'h00, 1'b1);
        rdc(8'h00, {24'h0, f});
        wr(8'h00, 32'h0000_00ff);
        f = 8'h00;
    end
    for (i = 0; i < 16; i++)
    begin
        pulse(8'h01 << i[2:0], 1'b0);
        rdc(8'h00, {24'h0, f});
        chk({31'h0, irq}, 32'h0);
        wr(8'h00, {24'h0, f});
        f = 8'h00;
    end
    for (i = 0; i < 40; i++)
    begin
        r = $urandom;
        wr(8'h0c, r);
        md = r[1:0];
        rdc(8'h0c, {30'h0, md});
        r = $urandom;
        pulse(r[7:0], r[8]);
        wr(8'h08, {24'h0, r[23:16]});
        f = f | r[23:16];
        r = $urandom;
        m = r[7:0];
        wr(8'h04, r);
        rdc(8'h00, {24'h0, f});
        rdc(8'h10, {21'h0, osc, cb, ca, f & m});
        chk({31'h0, irq}, {31'h0, |(f & m)});
        wr(8'h00, {24'h0, r[15:8]});
        f = f & ~r[15:8];
    end
    apb(1'b1, 8'h04, 32'h0000_00ff, 4'h0);
    rdc(8'h04, {24'h0, m});
    apb(1'b0, 8'h18, 32'h0, 4'hf);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h18, 32'h0000_00ff, 4'hf);
    chk({31'h0, err}, 32'h1);
    wr(8'h14, 32'h0000_00ff);
    wr(8'h08, 32'h1);
    f[0] = 1'b1;
    fork
        wr(8'h00, 32'h1);
        begin
            repeat (2) @(posedge clock);
            ev <= 8'h01;
            @(posedge clock);
            ev <= 8'h00;
        end
    join
    rdc(8'h00, {24'h0, f});
    rdc(8'h14, 32'h1);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h0);
    close_out;
end
endmodule
